// ===== rtl/rpc_top.sv
// receive path direct command interpreter: mask, amplitude, squelch, gain reset, preset
// assumes: commands arrive decoded from the spi slave as one-cycle strobes
//
// What this block does
// - preset picks peak detector at or below fc/16, mixer above
// - preset clears clip and gain-cut bits of config 3 outside active nfc
// - preset sets clip and gain-cut bits of config 3 in active nfc
// - mask command drops rx_on and disables receive framing
// - effective mask is command mask or running mask timer
// - unmask command raises rx_on and enables receive framing
// - unmask while mask timer runs enables reception and resets timer
// - mask and unmask only accepted with receiver enabled
// - mask and unmask chain freely and raise no interrupt
// - measure amplitude enables tx and detector, absolute adc, stores result
// - one result lsb equals 13.02 mVpp at antenna inputs
// - measure amplitude finishes within 25 us
// - measure amplitude needs operation enable and stable oscillator
// - measure amplitude blocks chaining and raises interrupt when finished
// - squelch accepted only with transmitter and receiver operating
// - accepted squelch executes only while rx_on is low
// - squelch finishes within 500 us, blocks chaining, no interrupt
// - gain reset initialises agc, squelch, rssi; chains; needs enable and oscillator
// - gain reset stops squelch, clears setting, loads manual gain from config 4
`timescale 1ns/1ps
`include "rpc_regs.svh"
module rpc_top
  import rpc_pkg::*;
#(
  parameter int MEAS_CYC = `RPC_T_MEAS_US * `RPC_CLK_MHZ,
  parameter int SQ_CYC   = `RPC_T_SQ_US * `RPC_CLK_MHZ
)
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // decoded command
  input  wire logic       cmd_valid,
  input  wire logic [2:0] cmd_code,
  output logic            cmd_busy,
  output logic            term_irq,
  // register access
  input  wire logic       reg_wr,
  input  wire logic [5:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  output logic [7:0]      reg_rdata,
  // device state
  input  wire logic       op_en,
  input  wire logic       osc_stable,
  input  wire logic       rx_en,
  input  wire logic       tx_en,
  input  wire logic [2:0] rx_rate,
  input  wire logic       nfc_active,
  input  wire logic [7:0] rx_cfg4,
  // mask receive timer
  input  wire logic       mask_tmr_running,
  output logic            mask_tmr_clear,
  // receiver control
  output logic            rx_on,
  output logic            framing_en,
  output logic            amd_sel,
  output logic [7:0]      rx_cfg3,
  // amplitude measurement
  output logic            tx_force_on,
  output logic            amp_det_en,
  output logic            adc_abs_mode,
  output logic            adc_start,
  input  wire logic       adc_done,
  input  wire logic [7:0] adc_data,
  // squelch and gain
  output logic            squelch_run,
  input  wire logic       squelch_done,
  output logic            gain_init,
  output logic            squelch_clear,
  output logic [7:0]      manual_gain
);

  // ----------------------------------------
  // command acceptance
  // ----------------------------------------
  rpc_state_t state_r;
  logic       mask_cmd_r;
  logic [7:0] adc_out_r;
  logic       sq_pend_r;
  logic       is_pre, is_msk, is_unm, is_meas, is_sq, is_rg;
  logic       ok_pre, ok_msk, ok_unm, ok_meas, ok_sq, ok_rg;
  logic       idle;
  logic       tmo_run, tmo_exp, tmo_start, tmo_stop;
  logic [15:0] tmo_limit;
  logic       pre_amd;
  logic [7:0] pre_cfg3;
  logic       meas_end, sq_end;

  assign idle    = (state_r == RPC_ST_IDLE);
  assign is_pre  = cmd_valid && (cmd_code == RPC_CMD_PRESET);
  assign is_msk  = cmd_valid && (cmd_code == RPC_CMD_MASK);
  assign is_unm  = cmd_valid && (cmd_code == RPC_CMD_UNMASK);
  assign is_meas = cmd_valid && (cmd_code == RPC_CMD_MEAS_AMP);
  assign is_sq   = cmd_valid && (cmd_code == RPC_CMD_SQUELCH);
  assign is_rg   = cmd_valid && (cmd_code == RPC_CMD_RESET_GAIN);

  // a running measure or squelch blocks commands, except gain reset which must stop a squelch; anything not ok is dropped silently
  assign ok_pre  = is_pre && idle;
  assign ok_msk  = is_msk && idle && rx_en;
  assign ok_unm  = is_unm && idle && rx_en;
  assign ok_meas = is_meas && idle && !sq_pend_r && op_en && osc_stable;
  assign ok_sq   = is_sq && idle && !sq_pend_r && tx_en && rx_en;
  assign ok_rg   = is_rg && (state_r != RPC_ST_MEAS) && op_en && osc_stable;

  assign meas_end = (state_r == RPC_ST_MEAS) && (adc_done || tmo_exp);
  assign sq_end   = (state_r == RPC_ST_SQUELCH) && (squelch_done || tmo_exp);
  // squelch only starts once rx_on is low
  assign tmo_start = (ok_meas) || (sq_pend_r && !rx_on && idle && !ok_rg);
  assign tmo_stop  = meas_end || sq_end || ok_rg;
  assign tmo_limit = ok_meas ? 16'(MEAS_CYC) : 16'(SQ_CYC);

  rpc_tmo #(
    .W (16)
  ) u_tmo (
    .sys_clk (sys_clk),
    .rst     (rst),
    .start   (tmo_start),
    .stop    (tmo_stop),
    .limit   (tmo_limit),
    .running (tmo_run),
    .expired (tmo_exp)
  );

  rpc_preset u_preset (
    .rx_rate    (rx_rate),
    .nfc_active (nfc_active),
    .cfg3_cur   (rx_cfg3),
    .amd_sel    (pre_amd),
    .cfg3_new   (pre_cfg3)
  );

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      state_r <= RPC_ST_IDLE;
    else
    begin
      case (state_r)
        RPC_ST_IDLE:
          if (ok_meas)
            state_r <= RPC_ST_MEAS;
          else if (tmo_start)
            state_r <= RPC_ST_SQUELCH;
        RPC_ST_MEAS:
          if (meas_end)
            state_r <= RPC_ST_IDLE;
        RPC_ST_SQUELCH:
          if (sq_end || ok_rg)
            state_r <= RPC_ST_IDLE;
        default:
          state_r <= RPC_ST_IDLE;
      endcase
    end
  end

  // accepted squelch waits here for rx_on to fall; gain reset cancels it
  always_ff @(posedge sys_clk)
  begin
    if (rst || ok_rg || tmo_start)
      sq_pend_r <= 1'b0;
    else if (ok_sq)
      sq_pend_r <= 1'b1;
  end

  // pending squelch also counts as busy: chaining is not allowed
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      cmd_busy <= 1'b0;
    else
      cmd_busy <= !((state_r == RPC_ST_IDLE && !tmo_start && !ok_meas && !ok_sq && !sq_pend_r)
                    || meas_end || sq_end || ok_rg);
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      term_irq <= 1'b0;
    else
      term_irq <= meas_end;
  end

  // ----------------------------------------
  // receive masking
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      mask_cmd_r <= 1'b0;
    else if (ok_msk)
      mask_cmd_r <= 1'b1;
    else if (ok_unm)
      mask_cmd_r <= 1'b0;
  end

  // timer mask is ignored the cycle unmask clears it
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rx_on          <= 1'b0;
      framing_en     <= 1'b0;
      mask_tmr_clear <= 1'b0;
    end
    else
    begin
      rx_on          <= rx_en && !mask_cmd_r && !(mask_tmr_running && !mask_tmr_clear);
      framing_en     <= rx_en && !mask_cmd_r && !(mask_tmr_running && !mask_tmr_clear);
      mask_tmr_clear <= ok_unm && mask_tmr_running;
    end
  end

  // ----------------------------------------
  // amplitude measurement
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      tx_force_on  <= 1'b0;
      amp_det_en   <= 1'b0;
      adc_abs_mode <= 1'b0;
      adc_start    <= 1'b0;
    end
    else
    begin
      tx_force_on  <= ok_meas || (state_r == RPC_ST_MEAS && !meas_end);
      amp_det_en   <= ok_meas || (state_r == RPC_ST_MEAS && !meas_end);
      adc_abs_mode <= ok_meas || (state_r == RPC_ST_MEAS && !meas_end);
      adc_start    <= ok_meas;
    end
  end

  // raw code kept as is; scale is RPC_AMP_LSB_UVPP per step
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      adc_out_r <= `RPC_ADC_RESET;
    else if (meas_end)
      adc_out_r <= adc_data;
  end

  // ----------------------------------------
  // squelch and gain
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      squelch_run   <= 1'b0;
      gain_init     <= 1'b0;
      squelch_clear <= 1'b0;
      manual_gain   <= 8'h00;
    end
    else
    begin
      squelch_run   <= (tmo_start && !ok_meas) || (state_r == RPC_ST_SQUELCH && !sq_end && !ok_rg);
      gain_init     <= ok_rg;
      squelch_clear <= ok_rg;
      if (ok_rg)
        manual_gain <= rx_cfg4;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // preset wins over a same-cycle register write
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rx_cfg3 <= `RPC_CFG3_RESET;
      amd_sel <= 1'b0;
    end
    else if (ok_pre)
    begin
      rx_cfg3 <= pre_cfg3;
      amd_sel <= pre_amd;
    end
    else if (reg_wr && reg_addr == `RPC_ADDR_RX_CFG3)
      rx_cfg3 <= reg_wdata;
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      reg_rdata <= 8'h00;
    else if (reg_addr == `RPC_ADDR_RX_CFG3)
      reg_rdata <= rx_cfg3;
    else if (reg_addr == `RPC_ADDR_ADC_OUT)
      reg_rdata <= adc_out_r;
    else if (reg_addr == `RPC_ADDR_STATUS)
      reg_rdata <= {5'h00, sq_pend_r, mask_cmd_r, cmd_busy};
    else
      reg_rdata <= 8'h00;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_mask_cmd;
    ok_msk;
  endsequence
  sequence s_rx_dropped;
    ##2 (!rx_on && !framing_en);
  endsequence

  property p_mask_drops;
    @(posedge sys_clk) disable iff (rst) s_mask_cmd |-> s_rx_dropped;
  endproperty
  a_mask_drops: assert property (p_mask_drops) else $error("mask did not drop rx_on");

  property p_timer_masks;
    @(posedge sys_clk) disable iff (rst) (mask_tmr_running && !mask_tmr_clear) |=> !rx_on;
  endproperty
  a_timer_masks: assert property (p_timer_masks) else $error("timer mask ignored");

  property p_unmask_opens;
    @(posedge sys_clk) disable iff (rst) (ok_unm && rx_en) ##1 rx_en [*2] |-> rx_on;
  endproperty
  a_unmask_opens: assert property (p_unmask_opens) else $error("unmask did not raise rx_on");

  property p_rx_en_gate;
    @(posedge sys_clk) disable iff (rst) (is_msk && !rx_en) |=> $stable(mask_cmd_r);
  endproperty
  a_rx_en_gate: assert property (p_rx_en_gate) else $error("mask taken with receiver off");

  // cycles spent measuring; a delay range this long would choke the tools
  logic [15:0] meas_age_r;
  always_ff @(posedge sys_clk)
  begin
    if (rst || state_r != RPC_ST_MEAS)
      meas_age_r <= 16'h0000;
    else if (meas_age_r != 16'hffff)
      meas_age_r <= meas_age_r + 16'h0001;
  end

  property p_meas_bound;
    @(posedge sys_clk) disable iff (rst) (state_r == RPC_ST_MEAS) |-> (meas_age_r <= 16'(MEAS_CYC));
  endproperty
  a_meas_bound: assert property (p_meas_bound) else $error("measure overran");

  property p_meas_irq;
    @(posedge sys_clk) disable iff (rst) meas_end |=> term_irq;
  endproperty
  a_meas_irq: assert property (p_meas_irq) else $error("measure end gave no interrupt");

  property p_meas_gate;
    @(posedge sys_clk) disable iff (rst) (is_meas && !(op_en && osc_stable)) |=> !adc_start;
  endproperty
  a_meas_gate: assert property (p_meas_gate) else $error("measure started without enable");

  property p_sq_gate;
    @(posedge sys_clk) disable iff (rst) $rose(squelch_run) |-> $past(!rx_on);
  endproperty
  a_sq_gate: assert property (p_sq_gate) else $error("squelch ran with rx_on high");

  property p_rg_load;
    @(posedge sys_clk) disable iff (rst) ok_rg |=> (manual_gain == $past(rx_cfg4) && !squelch_run && gain_init);
  endproperty
  a_rg_load: assert property (p_rg_load) else $error("gain reset incomplete");

  property p_no_irq_chain;
    @(posedge sys_clk) disable iff (rst) (ok_msk || ok_unm || ok_rg || ok_sq) |=> !term_irq;
  endproperty
  a_no_irq_chain: assert property (p_no_irq_chain) else $error("unexpected interrupt");

  property p_preset_cfg3;
    @(posedge sys_clk) disable iff (rst) ok_pre |=> (rx_cfg3[1:0] == {2{$past(nfc_active)}});
  endproperty
  a_preset_cfg3: assert property (p_preset_cfg3) else $error("preset config 3 wrong");
endmodule : rpc_top

// ===== rtl/rpc_regs.svh
// offsets, field positions, reset values and timing counts for the receive path commands
// assumes: included by bare name from the top and preset modules
`ifndef RPC_REGS_SVH
`define RPC_REGS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define RPC_ADDR_RX_CFG3   6'h0c
`define RPC_ADDR_ADC_OUT   6'h25
`define RPC_ADDR_STATUS    6'h26

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define RPC_CFG3_CLIP_BIT  1
`define RPC_CFG3_GCUT_BIT  0
`define RPC_CFG3_RESET     8'h00
`define RPC_ADC_RESET      8'h00
`define RPC_RATE_FC16      3'h3

// ----------------------------------------
// timing
// ----------------------------------------
`define RPC_CLK_MHZ        100
`define RPC_T_MEAS_US      25
`define RPC_T_SQ_US        500
// amplitude result scale, microvolts peak-peak per lsb at the antenna inputs
`define RPC_AMP_LSB_UVPP   13020

`endif

// ===== rtl/rpc_pkg.sv
// types shared by the receive path command logic
// assumes: nothing beyond the regs header
package rpc_pkg;
  typedef enum logic [2:0] {
    RPC_CMD_PRESET,
    RPC_CMD_MASK,
    RPC_CMD_UNMASK,
    RPC_CMD_MEAS_AMP,
    RPC_CMD_SQUELCH,
    RPC_CMD_RESET_GAIN
  } rpc_cmd_t;

  typedef enum {
    RPC_ST_IDLE,
    RPC_ST_MEAS,
    RPC_ST_SQUELCH
  } rpc_state_t;
endpackage : rpc_pkg

// ===== rtl/rpc_tmo.sv
// timeout counter shared by the long-running commands
// assumes: start and stop are one-cycle pulses, limit stable while running
`timescale 1ns/1ps
module rpc_tmo
  import rpc_pkg::*;
#(
  parameter int W = 16
)
(
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // control
  input  wire logic         start,
  input  wire logic         stop,
  input  wire logic [W-1:0] limit,
  // status
  output logic              running,
  output logic              expired
);
  logic [W-1:0] cnt_r;

  always_ff @(posedge sys_clk)
  begin
    if (rst || stop)
    begin
      cnt_r   <= '0;
      running <= 1'b0;
      expired <= 1'b0;
    end
    else if (start)
    begin
      cnt_r   <= limit;
      running <= 1'b1;
      expired <= 1'b0;
    end
    else if (running)
    begin
      cnt_r   <= cnt_r - {{(W-1){1'b0}}, 1'b1};
      expired <= (cnt_r == {{(W-1){1'b0}}, 1'b1});
      running <= (cnt_r != {{(W-1){1'b0}}, 1'b1});
    end
    else
    begin
      expired <= 1'b0;
    end
  end
endmodule : rpc_tmo

// ===== rtl/rpc_preset.sv
// analog preset decode for receiver configuration bits
// assumes: rate code grows with bit rate, fc/16 at RPC_RATE_FC16
`timescale 1ns/1ps
`include "rpc_regs.svh"
module rpc_preset
  import rpc_pkg::*;
(
  // mode inputs
  input  wire logic [2:0] rx_rate,
  input  wire logic       nfc_active,
  input  wire logic [7:0] cfg3_cur,
  // preset values
  output logic            amd_sel,
  output logic [7:0]      cfg3_new
);
  always_comb
  begin
    // peak detector up to fc/16, mixer above
    amd_sel  = (rx_rate > `RPC_RATE_FC16);
    cfg3_new = cfg3_cur;
    cfg3_new[`RPC_CFG3_CLIP_BIT] = nfc_active;
    cfg3_new[`RPC_CFG3_GCUT_BIT] = nfc_active;
  end
endmodule : rpc_preset

// ===== test/rpc_afe_model.sv
// analog front end stand-in: converter, squelch engine, mask receive timer
// assumes: same clock and reset as rpc_top, bench sets delays and results
`timescale 1ns/1ps
module rpc_afe_model
  import rpc_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // bench control
  input  wire logic [7:0] dly,
  input  wire logic [7:0] res,
  input  wire logic       tmr_go,
  // block side
  input  wire logic       adc_start,
  input  wire logic       squelch_run,
  input  wire logic       mask_tmr_clear,
  output logic            adc_done,
  output logic [7:0]      adc_data,
  output logic            squelch_done,
  output logic            mask_tmr_running
);
  logic [7:0] acnt_r;
  logic [7:0] scnt_r;
  logic       sact_r;

  // ----------------------------------------
  // converter
  // ----------------------------------------
  // data is only valid in the done cycle, garbage otherwise
  always_ff @(posedge sys_clk)
  begin
    adc_done <= 1'b0;
    adc_data <= ~adc_data;
    if (rst)
      acnt_r <= 8'h00;
    else if (adc_start)
      acnt_r <= dly;
    else if (acnt_r != 8'h00)
      acnt_r <= acnt_r - 8'h01;
    if (!rst && acnt_r == 8'h01)
    begin
      adc_done <= 1'b1;
      adc_data <= res;
    end
  end

  // ----------------------------------------
  // squelch engine and mask timer
  // ----------------------------------------
  always_ff @(posedge sys_clk)
  begin
    squelch_done <= !rst && sact_r && scnt_r == 8'h01;
    sact_r       <= !rst && squelch_run;
    if (squelch_run && !sact_r)
      scnt_r <= dly;
    else if (scnt_r != 8'h00)
      scnt_r <= scnt_r - 8'h01;
    if (rst || mask_tmr_clear)
      mask_tmr_running <= 1'b0;
    else if (tmr_go)
      mask_tmr_running <= 1'b1;
  end
endmodule : rpc_afe_model

// ===== test/rpc_top_bench.sv
// self-checking bench for the receive path command block
// assumes: rpc_afe_model answers the analog side, short timeouts
`timescale 1ns/1ps
`include "rpc_regs.svh"
module rpc_top_bench;
  import rpc_pkg::*;
  logic       sys_clk = 0, rst = 1, cmd_valid = 0, reg_wr = 0;
  logic [2:0] cmd_code = 0, rx_rate = 0;
  logic [5:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, reg_rdata, rx_cfg4 = 0, adc_data, rx_cfg3, manual_gain;
  logic       op_en = 1, osc_stable = 1, rx_en = 1, tx_en = 1, nfc_active = 0;
  logic       cmd_busy, term_irq, mask_tmr_running, mask_tmr_clear, rx_on, framing_en;
  logic       amd_sel, tx_force_on, amp_det_en, adc_abs_mode, adc_start, adc_done;
  logic       squelch_run, squelch_done, gain_init, squelch_clear, tmr_go = 0;
  logic [7:0] dly = 8'h05, res = 8'h00, d;
  int         error_cnt = 0, n_checks = 0, irq_n = 0, clr_n = 0, st_n = 0, gi_n = 0, sc_n = 0, n;

  rpc_top #(.MEAS_CYC(20), .SQ_CYC(50)) rpc_top_inst (
    .sys_clk, .rst, .cmd_valid, .cmd_code, .cmd_busy, .term_irq, .reg_wr, .reg_addr,
    .reg_wdata, .reg_rdata, .op_en, .osc_stable, .rx_en, .tx_en, .rx_rate, .nfc_active,
    .rx_cfg4, .mask_tmr_running, .mask_tmr_clear, .rx_on, .framing_en, .amd_sel, .rx_cfg3,
    .tx_force_on, .amp_det_en, .adc_abs_mode, .adc_start, .adc_done, .adc_data,
    .squelch_run, .squelch_done, .gain_init, .squelch_clear, .manual_gain);
  rpc_afe_model rpc_afe_model_inst (
    .sys_clk, .rst, .dly, .res, .tmr_go, .adc_start, .squelch_run, .mask_tmr_clear,
    .adc_done, .adc_data, .squelch_done, .mask_tmr_running);

  always #5 sys_clk = ~sys_clk;
  // pulse outputs are counted so a scenario can compare deltas
  always @(posedge sys_clk)
  begin
    irq_n += (!rst && term_irq === 1'b1);
    clr_n += (!rst && mask_tmr_clear === 1'b1);
    st_n += (!rst && adc_start === 1'b1);
    gi_n += (!rst && gain_init === 1'b1);
    sc_n += (!rst && squelch_clear === 1'b1);
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic give_verdict;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(negedge sys_clk);
  endtask : cyc

  task automatic cmd(input logic [2:0] c);
    @(negedge sys_clk);
    cmd_valid = 1;
    cmd_code = c;
    @(negedge sys_clk);
    cmd_valid = 0;
  endtask : cmd

  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    @(negedge sys_clk);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = v;
    @(negedge sys_clk);
    reg_wr = 0;
  endtask : wr

  task automatic rd(input logic [5:0] a, output logic [7:0] v);
    @(negedge sys_clk);
    reg_addr = a;
    cyc(2);
    v = reg_rdata;
  endtask : rd

  // s: 0 irq high, 1 busy low, 2 squelch running; k counts cycles waited
  task automatic wt(input int s, output int k);
    for (k = 1; k <= 200; k++)
    begin
      @(negedge sys_clk);
      if ((s == 0 && term_irq === 1'b1) || (s == 1 && cmd_busy === 1'b0) || (s == 2 && squelch_run === 1'b1))
        return;
    end
    error_cnt++;
    $display("[ERR] %0t wait ran out", $time);
    give_verdict();
  endtask : wt

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_preset;
    wr(`RPC_ADDR_RX_CFG3, 8'hff);
    rd(`RPC_ADDR_RX_CFG3, d);
    chk(d, 8'hff);
    rx_rate = `RPC_RATE_FC16;
    cmd(0);
    rd(`RPC_ADDR_RX_CFG3, d);
    chk({7'h0, amd_sel}, 8'h00);
    chk(d, 8'hfc);
    rx_rate = 3'h4;
    nfc_active = 1;
    cmd(0);
    rd(`RPC_ADDR_RX_CFG3, d);
    chk({7'h0, amd_sel}, 8'h01);
    chk(rx_cfg3, 8'hff);
    nfc_active = 0;
  endtask : t_preset

  task automatic t_mask;
    cmd(2);
    cyc(3);
    chk({rx_on, framing_en}, 8'h03);
    cmd(1);
    cyc(3);
    chk({rx_on, framing_en}, 8'h00);
    cmd(2);
    rx_en = 0;
    cmd(1);
    rx_en = 1;
    cyc(3);
    chk({rx_on, framing_en}, 8'h03);
    tmr_go = 1;
    cyc(1);
    tmr_go = 0;
    cyc(3);
    chk({7'h0, rx_on}, 8'h00);
    n = clr_n;
    cmd(2);
    cyc(3);
    chk(clr_n - n, 8'h01);
    chk({rx_on, mask_tmr_running}, 8'h02);
    chk(irq_n, 8'h00);
  endtask : t_mask

  task automatic t_meas;
    op_en = 0;
    cmd(3);
    cyc(3);
    chk({st_n[6:0], cmd_busy}, 8'h00);
    op_en = 1;
    res = 8'h5a;
    cmd(3);
    cyc(1);
    chk({tx_force_on, amp_det_en, adc_abs_mode, cmd_busy}, 8'h0f);
    cmd(1);
    wt(0, n);
    cyc(1);
    chk(irq_n, 8'h01);
    chk({tx_force_on, amp_det_en, rx_on, cmd_busy}, 8'h02);
    rd(`RPC_ADDR_ADC_OUT, d);
    chk(d, 8'h5a);
    // converter answers only after 60 cycles, design must give up on its own first
    dly = 8'h3c;
    cmd(3);
    wt(0, n);
    chk(n <= 22, 8'h01);
    cyc(60);
  endtask : t_meas

  task automatic t_squelch;
    tx_en = 0;
    cmd(4);
    cyc(3);
    chk({7'h0, cmd_busy}, 8'h00);
    tx_en = 1;
    cmd(4);
    cyc(4);
    chk({cmd_busy, squelch_run}, 8'h02);
    op_en = 0;
    n = gi_n;
    cmd(5);
    cyc(2);
    chk(gi_n - n, 8'h00);
    op_en = 1;
    rx_cfg4 = 8'h3c;
    cmd(5);
    cyc(3);
    chk({gi_n[3:0] - n[3:0], sc_n[3:0]}, 8'h11);
    chk({7'h0, cmd_busy}, 8'h00);
    chk(manual_gain, 8'h3c);
    cmd(1);
    dly = 8'h50;
    cmd(4);
    wt(2, n);
    wt(1, n);
    chk(n <= 52, 8'h01);
    chk(irq_n, 8'h02);
    // gain reset must stop a squelch that is already running
    cmd(4);
    wt(2, n);
    cmd(5);
    cyc(2);
    chk({cmd_busy, squelch_run}, 8'h00);
    // engine answers early, squelch must end on its done pulse
    dly = 8'h05;
    cmd(4);
    wt(2, n);
    wt(1, n);
    chk(n < 10, 8'h01);
  endtask : t_squelch

  initial
  begin
    cyc(16);
    rst = 0;
    t_preset();
    t_mask();
    t_meas();
    t_squelch();
    give_verdict();
  end
endmodule : rpc_top_bench
